/* shared/ssp_cfg.svh */
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ---------------------------------------------------------------
// opcode encoding: upper nibble zero, bit 3 ignored, low 3 bits
// ---------------------------------------------------------------
`define SSP_OPC_UPPER 4'h0
`define SSP_OPC_SETWE 3'h6
`define SSP_OPC_CLRWE 3'h4
`define SSP_OPC_SRD 3'h5
`define SSP_OPC_SWR 3'h1
`define SSP_OPC_READ 3'h3
`define SSP_OPC_WRITE 3'h2

// ---------------------------------------------------------------
// frame bit counts (last index of a phase)
// ---------------------------------------------------------------
`define SSP_BYTE_LAST 4'h7
`define SSP_ADDR_LAST 4'hf

// ---------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------
`define SSP_AW 13
`define SSP_DEPTH 8192

// ---------------------------------------------------------------
// status byte field positions
// ---------------------------------------------------------------
`define SSP_SB_PPE 7
`define SSP_SB_RFU_HI 6
`define SSP_SB_RFU_LO 4
`define SSP_SB_BP_HI 3
`define SSP_SB_BP_LO 2
`define SSP_SB_WLAT 1
`define SSP_SB_BUSY 0

// ---------------------------------------------------------------
// block protect levels
// ---------------------------------------------------------------
`define SSP_BP_NONE 2'h0
`define SSP_BP_QTR 2'h1
`define SSP_BP_HALF 2'h2
`define SSP_BP_ALL 2'h3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SSP_WLAT_RST 1'b0
`define SSP_BUSY_RST 1'b0
`define SSP_CS_IDLE 1'b1

// ---------------------------------------------------------------
// self-timed write cycle
// ---------------------------------------------------------------
`define SSP_TWC_US 5000
`define SSP_CLK_NS 10
`define SSP_TWC_CYC ((`SSP_TWC_US * 1000) / `SSP_CLK_NS)
`define SSP_TMR_W 19

`endif

/* shared/ssp_pkg.sv */
package ssp_pkg;

    // nonvolatile part of the status byte
    typedef struct packed {
        logic protect_pin_enable;
        logic block_protect_hi;
        logic block_protect_lo;
    } ssp_nv_t;

    // full status state as held by the control domain
    typedef struct packed {
        ssp_nv_t nv;
        logic write_enable_latch;
        logic busy_flag;
    } ssp_sts_t;

    // array program request
    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] data;
    } ssp_prg_t;

    // decoded opcode
    typedef enum logic [2:0] {
        OP_SETWE, OP_CLRWE, OP_SRD, OP_SWR, OP_READ, OP_WRITE, OP_BAD
    } ssp_op_t;

    // command left behind by a frame for execution at chip select rise
    typedef enum logic [1:0] {
        CAP_NONE, CAP_SETWE, CAP_CLRWE, CAP_SWR
    } ssp_cap_t;

    // link-side frame states
    typedef enum logic [2:0] {
        L_OPCODE, L_ADDR, L_READ, L_STATUS, L_SRDATA, L_TAIL, L_DEAD
    } ssp_lst_t;

    // kind of internal write cycle
    typedef enum logic {
        JOB_STATUS, JOB_ARRAY
    } ssp_job_t;

endpackage : ssp_pkg

/* verilog/ssp_status_protect.sv */
`timescale 1ns/1ps
`include "ssp_cfg.svh"

module ssp_status_protect #(
    parameter int WRITE_CYCLES = `SSP_TWC_CYC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    output logic SO,
    output logic SO_OE,
    input wire logic WP_N,
    input wire ssp_pkg::ssp_nv_t NV_RESTORE,
    output ssp_pkg::ssp_nv_t NV_STORE,
    output logic NV_STORE_STB,
    input wire logic PRG_REQ,
    input wire ssp_pkg::ssp_prg_t PRG,
    output logic PRG_ACCEPT,
    output logic PRG_REJECT,
    output logic BUSY,
    output logic WE_LATCH
);

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------

    // opcode decode; bit 3 is a don't-care in every opcode
    function automatic ssp_pkg::ssp_op_t decode_opc(input logic [7:0] opc);
        ssp_pkg::ssp_op_t op;
        op = ssp_pkg::OP_BAD;
        if (opc[7:4] == `SSP_OPC_UPPER) begin
            unique case (opc[2:0])
                `SSP_OPC_SETWE: op = ssp_pkg::OP_SETWE;
                `SSP_OPC_CLRWE: op = ssp_pkg::OP_CLRWE;
                `SSP_OPC_SRD: op = ssp_pkg::OP_SRD;
                `SSP_OPC_SWR: op = ssp_pkg::OP_SWR;
                `SSP_OPC_READ: op = ssp_pkg::OP_READ;
                `SSP_OPC_WRITE: op = ssp_pkg::OP_WRITE;
                default: op = ssp_pkg::OP_BAD;
            endcase
        end
        return op;
    endfunction : decode_opc

    // block protection: ranges always run up to the top address
    function automatic logic blk_protected(input logic [1:0] bp,
                                           input logic [12:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (bp)
            `SSP_BP_NONE: hit = 1'b0;
            `SSP_BP_QTR: hit = (addr[12:11] == 2'h3);
            `SSP_BP_HALF: hit = addr[12];
            `SSP_BP_ALL: hit = 1'b1;
        endcase
        return hit;
    endfunction : blk_protected

    // ---------------------------------------------------------------
    // control domain state (CLOCK)
    // ---------------------------------------------------------------
    logic cs_meta_r; // first synchroniser stage of chip select
    logic cs_sync_r; // synchronised chip select
    logic cs_last_r; // previous value, for edge detect
    logic wp_meta_r; // first synchroniser stage of protect pin
    logic wp_sync_r; // synchronised protect pin
    logic wlat_r, wlat_nxt; // write enable latch
    logic busy_r, busy_nxt; // internal write cycle running
    ssp_pkg::ssp_nv_t nv_r, nv_nxt; // nonvolatile status bits
    ssp_pkg::ssp_nv_t pnv_r, pnv_nxt; // status value being written
    ssp_pkg::ssp_prg_t pprg_r, pprg_nxt; // array word being written
    ssp_pkg::ssp_job_t job_r, job_nxt; // kind of running write cycle
    logic [`SSP_TMR_W-1:0] tmr_r, tmr_nxt; // write cycle countdown
    logic seen_r, seen_nxt; // last frame marker consumed
    logic stb_r, stb_nxt; // nonvolatile store strobe
    logic acc_r, acc_nxt; // array request accepted
    logic rej_r, rej_nxt; // array request refused
    logic mem_we; // commit array word at end of cycle
    logic cs_rise; // end of a frame seen on CLOCK
    logic hw_lock; // hardware write protection active
    logic exec; // a new frame's command is due
    ssp_pkg::ssp_sts_t sts_now; // status state sent to the link

    // ---------------------------------------------------------------
    // link domain state (SCK)
    // ---------------------------------------------------------------
    ssp_pkg::ssp_lst_t lst_r, lst_nxt; // frame phase
    logic [3:0] cnt_r, cnt_nxt; // bits received within a phase
    logic [7:0] sh_r, sh_nxt; // input shifter
    logic [`SSP_AW-1:0] addr_r, addr_nxt; // read pointer
    ssp_pkg::ssp_cap_t cap_r, cap_nxt; // command handed to control
    logic [7:0] capd_r, capd_nxt; // status data handed to control
    logic tog_r, tog_nxt; // flips once per frame
    ssp_pkg::ssp_sts_t sts_meta_r; // first status sync stage
    ssp_pkg::ssp_sts_t sts_sync_r; // status as seen by the link
    logic so_r, so_nxt; // serial output bit
    logic oe_r, oe_nxt; // serial output enable
    logic [7:0] sts_byte; // status byte as shifted out
    logic [7:0] rd_byte; // array byte at read pointer
    ssp_pkg::ssp_op_t op_in; // opcode being completed

    // array storage, written by control, read by the link
    logic [7:0] mem_r [0:`SSP_DEPTH-1];

    // ---------------------------------------------------------------
    // control domain: synchronisers
    // ---------------------------------------------------------------

    // chip select and protect pin come from pins: two stages each
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cs_meta_r <= `SSP_CS_IDLE;
            cs_sync_r <= `SSP_CS_IDLE;
            cs_last_r <= `SSP_CS_IDLE;
            wp_meta_r <= 1'b1;
            wp_sync_r <= 1'b1;
        end else begin
            cs_meta_r <= CS_N;
            cs_sync_r <= cs_meta_r;
            cs_last_r <= cs_sync_r;
            wp_meta_r <= WP_N;
            wp_sync_r <= wp_meta_r;
        end
    end

    assign cs_rise = cs_sync_r & ~cs_last_r;
    assign hw_lock = ~wp_sync_r & nv_r.protect_pin_enable;
    // the link domain registers are quiet once select is high, so
    // sampling them at the synchronised rise sees settled values
    assign exec = cs_rise & (tog_r != seen_r);
    assign sts_now = '{nv: nv_r, write_enable_latch: wlat_r,
                       busy_flag: busy_r};

    // ---------------------------------------------------------------
    // control domain: command execution and write cycle
    // ---------------------------------------------------------------

    // next state of latch, busy, nonvolatile bits and timer
    always_comb begin
        wlat_nxt = wlat_r;
        busy_nxt = busy_r;
        nv_nxt = nv_r;
        pnv_nxt = pnv_r;
        pprg_nxt = pprg_r;
        job_nxt = job_r;
        tmr_nxt = tmr_r;
        seen_nxt = seen_r;
        stb_nxt = 1'b0;
        acc_nxt = 1'b0;
        rej_nxt = 1'b0;
        mem_we = 1'b0;
        if (cs_rise) begin
            seen_nxt = tog_r;
        end
        if (busy_r) begin
            // running cycle: count down, then commit and finish
            if (tmr_r != '0) begin
                tmr_nxt = tmr_r - `SSP_TMR_W'(1);
            end else begin
                busy_nxt = 1'b0;
                wlat_nxt = 1'b0;
                if (job_r == ssp_pkg::JOB_STATUS) begin
                    nv_nxt = pnv_r;
                    stb_nxt = 1'b1;
                end else begin
                    mem_we = 1'b1;
                end
            end
        end else if (exec) begin
            // frames during a cycle are dropped here, and all but status reads on the link
            unique case (cap_r)
                ssp_pkg::CAP_SETWE: wlat_nxt = 1'b1;
                ssp_pkg::CAP_CLRWE: wlat_nxt = 1'b0;
                ssp_pkg::CAP_SWR: begin
                    // locked status refuses even clearing the enable
                    if (wlat_r && !hw_lock) begin
                        pnv_nxt.protect_pin_enable =
                            capd_r[`SSP_SB_PPE];
                        pnv_nxt.block_protect_hi =
                            capd_r[`SSP_SB_BP_HI];
                        pnv_nxt.block_protect_lo =
                            capd_r[`SSP_SB_BP_LO];
                        job_nxt = ssp_pkg::JOB_STATUS;
                        busy_nxt = 1'b1;
                        tmr_nxt = `SSP_TMR_W'(WRITE_CYCLES - 1);
                    end
                end
                ssp_pkg::CAP_NONE: begin
                    // aborted or non-executing frame: nothing to do
                end
            endcase
        end
        if (PRG_REQ) begin
            // array request loses to a frame ending in the same cycle
            if (!busy_r && !exec && wlat_r
                && !blk_protected({nv_r.block_protect_hi,
                                   nv_r.block_protect_lo},
                                  PRG.addr)) begin
                pprg_nxt = PRG;
                job_nxt = ssp_pkg::JOB_ARRAY;
                busy_nxt = 1'b1;
                tmr_nxt = `SSP_TMR_W'(WRITE_CYCLES - 1);
                acc_nxt = 1'b1;
            end else begin
                rej_nxt = 1'b1;
            end
        end
    end

    // nonvolatile bits reload from the retained cells at reset
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wlat_r <= `SSP_WLAT_RST;
            busy_r <= `SSP_BUSY_RST;
            nv_r <= NV_RESTORE;
            pnv_r <= '0;
            pprg_r <= '0;
            job_r <= ssp_pkg::JOB_STATUS;
            tmr_r <= '0;
            seen_r <= 1'b0;
            stb_r <= 1'b0;
            acc_r <= 1'b0;
            rej_r <= 1'b0;
        end else begin
            wlat_r <= wlat_nxt;
            busy_r <= busy_nxt;
            nv_r <= nv_nxt;
            pnv_r <= pnv_nxt;
            pprg_r <= pprg_nxt;
            job_r <= job_nxt;
            tmr_r <= tmr_nxt;
            seen_r <= seen_nxt;
            stb_r <= stb_nxt;
            acc_r <= acc_nxt;
            rej_r <= rej_nxt;
        end
    end

    // array write port; storage has no reset by nature
    always_ff @(posedge CLOCK) begin
        if (mem_we) begin
            mem_r[pprg_r.addr] <= pprg_r.data;
        end
    end

    // ---------------------------------------------------------------
    // link domain: status view and read data
    // ---------------------------------------------------------------

    // status into the link; fields are quasi-static during a frame
    always_ff @(posedge SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sts_meta_r <= '0;
            sts_sync_r <= '0;
        end else begin
            sts_meta_r <= sts_now;
            sts_sync_r <= sts_meta_r;
        end
    end

    // status byte, busy echoed on the reserved bits
    always_comb begin
        sts_byte = 8'h00;
        sts_byte[`SSP_SB_PPE] = sts_sync_r.nv.protect_pin_enable;
        sts_byte[`SSP_SB_RFU_HI:`SSP_SB_RFU_LO] =
            {3{sts_sync_r.busy_flag}};
        sts_byte[`SSP_SB_BP_HI] = sts_sync_r.nv.block_protect_hi;
        sts_byte[`SSP_SB_BP_LO] = sts_sync_r.nv.block_protect_lo;
        sts_byte[`SSP_SB_WLAT] = sts_sync_r.write_enable_latch;
        sts_byte[`SSP_SB_BUSY] = sts_sync_r.busy_flag;
        rd_byte = mem_r[addr_r];
    end

    // ---------------------------------------------------------------
    // link domain: frame decoding on rising SCK
    // ---------------------------------------------------------------

    assign op_in = decode_opc(sh_nxt);

    // next frame phase, shifter, pointer and handed-over command
    always_comb begin
        lst_nxt = lst_r;
        cnt_nxt = cnt_r + 4'h1;
        sh_nxt = {sh_r[6:0], SI};
        addr_nxt = addr_r;
        cap_nxt = cap_r;
        capd_nxt = capd_r;
        tog_nxt = tog_r;
        unique case (lst_r)
            ssp_pkg::L_OPCODE: begin
                if (cnt_r == 4'h0) begin
                    // first bit: mark a new frame, drop the old command
                    tog_nxt = ~tog_r;
                    cap_nxt = ssp_pkg::CAP_NONE;
                end
                if (cnt_r == `SSP_BYTE_LAST) begin
                    cnt_nxt = 4'h0;
                    if (sts_sync_r.busy_flag
                        && op_in != ssp_pkg::OP_SRD) begin
                        lst_nxt = ssp_pkg::L_DEAD;
                    end else begin
                        unique case (op_in)
                            ssp_pkg::OP_SRD:
                                lst_nxt = ssp_pkg::L_STATUS;
                            ssp_pkg::OP_SETWE: begin
                                lst_nxt = ssp_pkg::L_TAIL;
                                cap_nxt = ssp_pkg::CAP_SETWE;
                            end
                            ssp_pkg::OP_CLRWE: begin
                                lst_nxt = ssp_pkg::L_TAIL;
                                cap_nxt = ssp_pkg::CAP_CLRWE;
                            end
                            ssp_pkg::OP_SWR:
                                lst_nxt = ssp_pkg::L_SRDATA;
                            ssp_pkg::OP_READ:
                                lst_nxt = ssp_pkg::L_ADDR;
                            ssp_pkg::OP_WRITE:
                                // array write frames are sequenced elsewhere
                                lst_nxt = ssp_pkg::L_DEAD;
                            ssp_pkg::OP_BAD:
                                lst_nxt = ssp_pkg::L_DEAD;
                        endcase
                    end
                end
            end
            ssp_pkg::L_ADDR: begin
                // upper address bits fall off the top of the pointer
                addr_nxt = {addr_r[`SSP_AW-2:0], SI};
                if (cnt_r == `SSP_ADDR_LAST) begin
                    cnt_nxt = 4'h0;
                    lst_nxt = ssp_pkg::L_READ;
                end
            end
            ssp_pkg::L_READ: begin
                // input ignored; pointer wraps at the top
                if (cnt_r == `SSP_BYTE_LAST) begin
                    cnt_nxt = 4'h0;
                    addr_nxt = addr_r + `SSP_AW'(1);
                end
            end
            ssp_pkg::L_STATUS: begin
                // status repeats for as long as select stays low
                if (cnt_r == `SSP_BYTE_LAST) begin
                    cnt_nxt = 4'h0;
                end
            end
            ssp_pkg::L_SRDATA: begin
                if (cnt_r == `SSP_BYTE_LAST) begin
                    cnt_nxt = 4'h0;
                    capd_nxt = sh_nxt;
                    cap_nxt = ssp_pkg::CAP_SWR;
                    lst_nxt = ssp_pkg::L_TAIL;
                end
            end
            ssp_pkg::L_TAIL: begin
                // any extra bit spoils a complete command
                cap_nxt = ssp_pkg::CAP_NONE;
                lst_nxt = ssp_pkg::L_DEAD;
            end
            ssp_pkg::L_DEAD: begin
                cnt_nxt = cnt_r;
            end
            default: begin
                lst_nxt = ssp_pkg::L_DEAD;
            end
        endcase
    end

    // frame state clears whenever select is high
    always_ff @(posedge SCK or posedge CS_N) begin
        if (CS_N) begin
            lst_r <= ssp_pkg::L_OPCODE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            addr_r <= '0;
        end else begin
            lst_r <= lst_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
        end
    end

    // handed-over command must outlive the frame, so it is not
    // cleared by select; the frame marker tells old from new
    always_ff @(posedge SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cap_r <= ssp_pkg::CAP_NONE;
            capd_r <= 8'h00;
            tog_r <= 1'b0;
        end else begin
            cap_r <= cap_nxt;
            capd_r <= capd_nxt;
            tog_r <= tog_nxt;
        end
    end

    // ---------------------------------------------------------------
    // link domain: serial output on falling SCK
    // ---------------------------------------------------------------

    // output bit chosen by the count of bits already taken
    always_comb begin
        so_nxt = 1'b0;
        oe_nxt = 1'b0;
        unique case (lst_r)
            ssp_pkg::L_STATUS: begin
                oe_nxt = 1'b1;
                so_nxt = sts_byte[~cnt_r[2:0]];
            end
            ssp_pkg::L_READ: begin
                oe_nxt = 1'b1;
                so_nxt = rd_byte[~cnt_r[2:0]];
            end
            default: begin
                // opcode, address, dead frames: output released
                oe_nxt = 1'b0;
            end
        endcase
    end

    // output released as soon as select goes high
    always_ff @(negedge SCK or posedge CS_N) begin
        if (CS_N) begin
            so_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            so_r <= so_nxt;
            oe_r <= oe_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign SO = so_r;
    assign SO_OE = oe_r;
    assign NV_STORE = nv_r;
    assign NV_STORE_STB = stb_r;
    assign PRG_ACCEPT = acc_r;
    assign PRG_REJECT = rej_r;
    assign BUSY = busy_r;
    assign WE_LATCH = wlat_r;

endmodule : ssp_status_protect

/* verif/ssp_asserts.sv */
`timescale 1ns/1ps
// ------------------------------------------
// checker on the top ports, one clock domain
// ------------------------------------------
module ssp_asserts #(
    parameter int WRITE_CYCLES = 200
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CS_N,
    input wire logic SO_OE,
    input wire ssp_pkg::ssp_nv_t NV_STORE,
    input wire logic NV_STORE_STB,
    input wire logic PRG_REQ,
    input wire logic PRG_ACCEPT,
    input wire logic PRG_REJECT,
    input wire logic BUSY,
    input wire logic WE_LATCH
);
    // slack beyond the WRITE_CYCLES cycles that busy stays high
    localparam int BMAX = WRITE_CYCLES + 8;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    a_one_answer: assert property (
        PRG_REQ |=> PRG_ACCEPT != PRG_REJECT) else $error("bad answer");
    a_busy_refuse: assert property (
        PRG_REQ && BUSY |=> PRG_REJECT) else $error("busy accept");
    a_latch_gate: assert property (
        PRG_REQ && !WE_LATCH |=> PRG_REJECT) else $error("latch clear accept");
    a_all_locked: assert property (
        PRG_REQ && NV_STORE.block_protect_hi && NV_STORE.block_protect_lo
        |=> PRG_REJECT) else $error("full protect accept");
    a_accept_busy: assert property (
        PRG_ACCEPT |-> BUSY) else $error("accept without cycle");
    a_cycle_bound: assert property (
        $rose(BUSY) |-> ##[1:BMAX] !BUSY) else $error("cycle too long");
    a_end_clears: assert property (
        $fell(BUSY) |-> !WE_LATCH) else $error("latch kept at cycle end");
    a_nv_commit: assert property (
        $changed(NV_STORE) |-> NV_STORE_STB) else $error("silent change");
    a_out_select: assert property (
        SO_OE |-> !CS_N) else $error("output on while deselected");
    c_accept: cover property (PRG_ACCEPT);
    c_commit: cover property (NV_STORE_STB);
    c_output: cover property (SO_OE);
endmodule : ssp_asserts

bind ssp_status_protect ssp_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SO_OE(SO_OE),
    .NV_STORE(NV_STORE), .NV_STORE_STB(NV_STORE_STB), .PRG_REQ(PRG_REQ),
    .PRG_ACCEPT(PRG_ACCEPT), .PRG_REJECT(PRG_REJECT), .BUSY(BUSY),
    .WE_LATCH(WE_LATCH));

/* verif/ssp_host.sv */
`timescale 1ns/1ps
// ------------------------------------------
// mode 0 host, link clock runs in frames only
// ------------------------------------------
module ssp_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [39:0] rx; // received bits, newest lowest
    logic oe_any; // output enable seen in the last frame
    initial begin
        sck = 1'b0;
        cs_n <= 1'b1; // late update gives frame logic a clean edge
        si = 1'b0;
        rx = '0;
        oe_any = 1'b0;
    end
    // n bits from the top of tx, 64 ns link period
    task automatic xfer(input logic [39:0] tx, input int n);
        cs_n = 1'b0;
        oe_any = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = tx[39 - i];
            #32 sck = 1'b1;
            // a released line floats away from its last level
            rx = {rx[38:0], so_oe ? so : ~so};
            oe_any = oe_any | so_oe;
            #32 sck = 1'b0;
        end
        #16 cs_n = 1'b1;
        si = ~si; // no stale level once released
        #80;
    endtask : xfer
endmodule : ssp_host

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int WC = 200; // short cycle keeps the run brief
    logic CLOCK, SYS_RST, SCK, CS_N, SI, SO, SO_OE, WP_N, NV_STORE_STB;
    logic PRG_REQ, PRG_ACCEPT, PRG_REJECT, BUSY, WE_LATCH;
    ssp_pkg::ssp_nv_t NV_RESTORE, NV_STORE;
    ssp_pkg::ssp_prg_t PRG;
    int fails = 0, checks = 0, cyc = 0;
    ssp_status_protect #(.WRITE_CYCLES(WC)) uut (.CLOCK(CLOCK),
        .SYS_RST(SYS_RST), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
        .SO_OE(SO_OE), .WP_N(WP_N), .NV_RESTORE(NV_RESTORE),
        .NV_STORE(NV_STORE), .NV_STORE_STB(NV_STORE_STB), .PRG_REQ(PRG_REQ),
        .PRG(PRG), .PRG_ACCEPT(PRG_ACCEPT), .PRG_REJECT(PRG_REJECT),
        .BUSY(BUSY), .WE_LATCH(WE_LATCH));
    ssp_host host (.sck(SCK), .cs_n(CS_N), .si(SI), .so(SO),
        .so_oe(SO_OE));
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // hang guard
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] op, input int n);
        host.xfer({op, 32'h0}, n);
    endtask : cmd
    task automatic sr(input logic [7:0] exp);
        host.xfer({8'h05, 32'h0}, 16);
        chk(host.rx[7:0], exp);
        chk({7'h0, host.oe_any}, 8'h01);
    endtask : sr
    task automatic wsr(input logic [7:0] d);
        cmd(8'h06, 8);
        host.xfer({8'h01, d, 24'h0}, 16);
    endtask : wsr
    // one array request, answer judged a cycle later
    task automatic prg(input logic [12:0] a, input logic [7:0] d, input ok);
        @(posedge CLOCK);
        PRG_REQ <= 1'b1;
        PRG <= '{a, d};
        @(posedge CLOCK);
        PRG_REQ <= 1'b0;
        #1 chk({6'h0, PRG_ACCEPT, PRG_REJECT}, {6'h0, ok, !ok});
    endtask : prg
    task automatic wt;
        for (int i = 0; i < 400 && BUSY !== 1'b0; i++) @(posedge CLOCK);
        #1 chk({7'h0, BUSY}, 8'h00);
    endtask : wt
    // protect pin moves on a clock edge like the array request inputs
    task automatic pin(input logic v);
        @(posedge CLOCK);
        WP_N <= v;
    endtask : pin
    task automatic t_array;
        prg(13'h1fff, 8'h5a, 1'b0);
        cmd(8'h06, 8);
        prg(13'h1fff, 8'h5a, 1'b1);
        prg(13'h0000, 8'h00, 1'b0);
        wt();
        chk({7'h0, WE_LATCH}, 8'h00);
        cmd(8'h06, 8);
        prg(13'h0000, 8'hc3, 1'b1);
        wt();
        host.xfer({8'h03, 16'hffff, 16'h0}, 40);
        chk(host.rx[15:8], 8'h5a);
        chk(host.rx[7:0], 8'hc3);
    endtask : t_array
    task automatic t_latch;
        cmd(8'h06, 8);
        pin(1'b0);
        cmd(8'h04, 7);
        chk({7'h0, WE_LATCH}, 8'h01);
        cmd(8'h04, 8);
        chk({7'h0, WE_LATCH}, 8'h00);
        pin(1'b1);
        cmd(8'h85, 16);
        chk({7'h0, host.oe_any}, 8'h00);
        cmd(8'h02, 32);
        chk({7'h0, host.oe_any}, 8'h00);
        cmd(8'h0d, 16);
        chk({7'h0, host.oe_any}, 8'h01);
    endtask : t_latch
    task automatic t_status_write_cmd;
        wsr(8'hff);
        sr(8'h73);
        cmd(8'h04, 8);
        chk({7'h0, WE_LATCH}, 8'h01);
        wt();
        chk({5'h0, NV_STORE}, 8'h07);
        sr(8'h8c);
        cmd(8'h06, 8);
        prg(13'h0000, 8'h00, 1'b0);
    endtask : t_status_write_cmd
    task automatic t_hwlock;
        pin(1'b0);
        wsr(8'h00);
        chk({7'h0, BUSY}, 8'h00);
        chk({5'h0, NV_STORE}, 8'h07);
        cmd(8'h04, 8);
        chk({7'h0, WE_LATCH}, 8'h00);
        pin(1'b1);
        wsr(8'h04);
        wt();
        chk({5'h0, NV_STORE}, 8'h01);
        cmd(8'h06, 8);
        prg(13'h1800, 8'h00, 1'b0);
        prg(13'h17ff, 8'h00, 1'b1);
        wt();
    endtask : t_hwlock
    // second reset: latch clears, retained bits come back
    task automatic t_reset;
        cmd(8'h06, 8);
        @(posedge CLOCK);
        NV_RESTORE <= 3'h5;
        SYS_RST <= 1'b1;
        repeat (3) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        sr(8'h84);
        chk({7'h0, WE_LATCH}, 8'h00);
    endtask : t_reset
    initial begin
        SYS_RST <= 1'b1;
        WP_N = 1'b1;
        NV_RESTORE = '0;
        PRG_REQ = 1'b0;
        PRG = '0;
        repeat (3) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        sr(8'h00);
        chk({7'h0, WE_LATCH}, 8'h00);
        t_array();
        t_latch();
        t_status_write_cmd();
        t_hwlock();
        t_reset();
        summarize();
    end
endmodule : tb_top
